// ===== rtl/fieldbus_monitor_regs.svh
// Register offsets, reset values, status codes and timing counts of the
// fieldbus node status monitor.
// Assumes a 20 MHz processing clock and a byte-addressed plain register port.
`ifndef FIELDBUS_MONITOR_REGS_SVH
`define FIELDBUS_MONITOR_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_PANEL_ALIAS   8'h00
`define OFS_NODE_ID       8'h04
`define OFS_VEL_FACTOR    8'h08
`define OFS_COMM_TIMEOUT  8'h0C
`define OFS_OPER_MODE     8'h10
`define OFS_DESC_MODE     8'h14
`define OFS_CONTROL       8'h18
`define OFS_STATUS        8'h20
`define OFS_COMM_STATUS   8'h24
`define OFS_WDOG_TIME     8'h28
`define OFS_AL_STATUS     8'h2C
`define OFS_ACTIVE_ALIAS  8'h30
`define OFS_PRODUCT       8'h34
`define OFS_REVISION      8'h38
`define OFS_IP_ADDR       8'h3C
`define OFS_SUBNET        8'h40
`define OFS_GATEWAY       8'h44

////////////////////////////////////////////////////////////////////////////
// Reset values and field positions
`define RST_NODE_ID       16'h0001
`define RST_VEL_FACTOR    7'h01
`define RST_OPER_MODE     2'h2
`define RST_DESC_MODE     2'h1
`define FACTOR_10         7'h0A
`define FACTOR_100        7'h64
`define CTRL_FAULT_CLR    0
`define STAT_FAULT_BIT    8
`define STAT_TUNNEL_BIT   9

////////////////////////////////////////////////////////////////////////////
// Generic link status codes
`define GEN_INITIALIZING  3'h1
`define GEN_STOPPED       3'h2
`define GEN_OPERATIONAL   3'h3
`define GEN_FAULTED       3'h4
`define GEN_FAILING       3'h5
`define GEN_PREOP         3'h6

// Run state codes, also used as request codes
`define RUN_CODE_INIT     3'h1
`define RUN_CODE_PREOP    3'h3
`define RUN_CODE_SAFEOP   3'h4
`define RUN_CODE_OP       3'h5
`define REQ_BOOTSTRAP     3'h6

////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_PERIOD_NS     50
`define MS_TIME_NS        1000000
`define MS_CYCLES   ((`MS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEC_MS            10'd999
`define GOOD_MAX          16'd6553
`define ERR_MAX           4'h9

`endif

// ===== rtl/fieldbus_monitor_pkg.sv
// Types shared by the fieldbus node status monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
package fieldbus_monitor_pkg;

	// Link run state machine
	typedef enum logic [1:0]
	{
		RUN_INIT,
		RUN_PREOP,
		RUN_SAFEOP,
		RUN_OP
	} run_state_e;

endpackage

// ===== rtl/frame_rate_counter.sv
// Per-second good and error frame counter feeding the communication status.
// Assumes a one-cycle millisecond tick and one-cycle frame pulses.
`include "fieldbus_monitor_regs.svh"

module frame_rate_counter
	import fieldbus_monitor_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	input  wire logic        ms_tick_in,
	input  wire logic        frame_ok_in,
	input  wire logic        frame_err_in,
	output logic      [15:0] comm_status_out
);

	logic [9:0]  ms_cnt_q;
	logic [15:0] good_q;
	logic [3:0]  err_q;
	logic        sec_end;

	assign sec_end = ms_tick_in && (ms_cnt_q == `SEC_MS);

	////////////////////////////////////////////////////////////////////////
	// Millisecond count within the current second
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ms_cnt_q <= 10'h000;
		else if (sec_end)
			ms_cnt_q <= 10'h000;
		else if (ms_tick_in)
			ms_cnt_q <= ms_cnt_q + 10'h001;
	end

	// Saturating counters; a frame on the boundary opens the next second
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			good_q <= 16'h0000;
			err_q  <= 4'h0;
		end
		else if (sec_end)
		begin
			good_q <= {15'h0000, frame_ok_in};
			err_q  <= {3'h0, frame_err_in};
		end
		else
		begin
			if (frame_ok_in && good_q != `GOOD_MAX)
				good_q <= good_q + 16'h0001;
			if (frame_err_in && err_q != `ERR_MAX)
				err_q <= err_q + 4'h1;
		end
	end

	// Packed as good * 10 + errors, one fractional digit
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			comm_status_out <= 16'h0000;
		else if (sec_end)
			comm_status_out <= 16'(good_q * 16'd10) + {12'h000, err_q};
	end

endmodule

// ===== rtl/fieldbus_node_status_monitor.sv
// Status and parameter logic of the fieldbus slave: alias selection,
// velocity scaling, link state tracking, timeout fault and diagnostics.
// Assumes master-side events come from frame logic on the same clock as
// one-cycle pulses, and a power-on reset marks each power cycle.
`include "fieldbus_monitor_regs.svh"

module fieldbus_node_status_monitor
	import fieldbus_monitor_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MS_CYCLES
)
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	// Master-side events and values
	input  wire logic        conn_open_in,
	input  wire logic        conn_lost_in,
	input  wire logic        state_req_in,
	input  wire logic [2:0]  state_req_code_in,
	input  wire logic        frame_ok_in,
	input  wire logic        frame_err_in,
	input  wire logic [15:0] stored_alias_in,
	input  wire logic [15:0] sync_manager_watchdog_time_in,
	input  wire logic [15:0] application_layer_status_in,
	input  wire logic [31:0] product_code_in,
	input  wire logic [15:0] revision_in,
	input  wire logic        ethernet_tunnelling_in,
	input  wire logic [31:0] ip_addr_in,
	input  wire logic [31:0] subnet_in,
	input  wire logic [31:0] gateway_in,
	// Velocity path
	input  wire logic [15:0] rx_target_velocity_in,
	input  wire logic [31:0] drive_actual_velocity_in,
	output logic      [31:0] target_velocity_out,
	output logic      [15:0] actual_velocity_out,
	// Status
	output logic      [15:0] node_alias_out,
	output logic      [15:0] node_identification_value_out,
	output logic      [2:0]  generic_link_status_out,
	output logic      [2:0]  link_run_state_out,
	output logic      [1:0]  operate_mode_out,
	output logic             fieldbus_timeout_fault_out
);

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [15:0] ms_cnt_q;
	logic        ms_tick;
	logic [15:0] panel_alias_q;
	logic [15:0] node_id_q;
	logic [6:0]  velocity_scale_factor_q;
	logic [15:0] comm_timeout_q;
	logic [1:0]  oper_mode_q;
	logic [1:0]  description_file_select_mode_q;
	logic [15:0] stored_alias_q;
	logic        alias_taken_q;
	logic        connected_q;
	logic        ever_open_q;
	logic        failing_q;
	run_state_e  run_q;
	logic [2:0]  link_status_q;
	logic        fault_q;
	logic [15:0] wd_ms_q;
	logic [9:0]  tout_ms_q;
	logic [15:0] tout_s_q;
	logic [15:0] comm_status;
	logic [31:0] read_mux;
	logic        fault_clr;
	logic        req_ok;
	logic        wd_expire;
	logic        loss;
	logic        tout_done;
	logic signed [31:0] target_d;
	logic signed [31:0] actual_div;

	////////////////////////////////////////////////////////////////////////
	// Millisecond timebase shared by watchdog, timeout and rate counter
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ms_cnt_q <= 16'h0000;
		else if (ms_tick)
			ms_cnt_q <= 16'h0000;
		else
			ms_cnt_q <= ms_cnt_q + 16'h0001;
	end

	assign ms_tick = (ms_cnt_q == MS_LAST);

	////////////////////////////////////////////////////////////////////////
	// Panel parameter writes; out-of-range values are dropped, not clipped
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			panel_alias_q                  <= 16'h0000;
			node_id_q                      <= `RST_NODE_ID;
			velocity_scale_factor_q        <= `RST_VEL_FACTOR;
			comm_timeout_q                 <= 16'h0000;
			oper_mode_q                    <= `RST_OPER_MODE;
			description_file_select_mode_q <= `RST_DESC_MODE;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `OFS_PANEL_ALIAS)
				panel_alias_q <= reg_wdata_in[15:0];
			else if (reg_addr_in == `OFS_NODE_ID)
			begin
				if (reg_wdata_in[15:0] != 16'h0000)
					node_id_q <= reg_wdata_in[15:0];
			end
			else if (reg_addr_in == `OFS_VEL_FACTOR)
			begin
				if (reg_wdata_in[31:0] == 32'h0000_0001 ||
				    reg_wdata_in[31:0] == 32'h0000_000A ||
				    reg_wdata_in[31:0] == 32'h0000_0064)
					velocity_scale_factor_q <= reg_wdata_in[6:0];
			end
			else if (reg_addr_in == `OFS_COMM_TIMEOUT)
				comm_timeout_q <= reg_wdata_in[15:0];
			else if (reg_addr_in == `OFS_OPER_MODE)
			begin
				if (reg_wdata_in[31:2] == 30'h0 && reg_wdata_in[1:0] != 2'h0)
					oper_mode_q <= reg_wdata_in[1:0];
			end
			else if (reg_addr_in == `OFS_DESC_MODE)
			begin
				if (reg_wdata_in[31:2] == 30'h0 && reg_wdata_in[1:0] != 2'h0)
					description_file_select_mode_q <= reg_wdata_in[1:0];
			end
		end
	end

	assign fault_clr = reg_wr_in && (reg_addr_in == `OFS_CONTROL) &&
	                   reg_wdata_in[`CTRL_FAULT_CLR];

	////////////////////////////////////////////////////////////////////////
	// Stored alias is caught once after reset release, so an update by the
	// master only shows after the next power cycle
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			stored_alias_q <= 16'h0000;
			alias_taken_q  <= 1'b0;
		end
		else if (!alias_taken_q)
		begin
			stored_alias_q <= stored_alias_in;
			alias_taken_q  <= 1'b1;
		end
	end

	// Panel alias wins whenever nonzero and follows its changes one clock later
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			node_alias_out <= 16'h0000;
		else if (panel_alias_q != 16'h0000)
			node_alias_out <= panel_alias_q;
		else if (alias_taken_q)
			node_alias_out <= stored_alias_q;
	end

	// Identification value goes out for the master only
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			node_identification_value_out <= `RST_NODE_ID;
		else
			node_identification_value_out <= node_id_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Velocity scaling; the actual value saturates rather than wrapping
	assign target_d   = 32'(signed'(rx_target_velocity_in)) *
	                    32'(signed'({9'h000, velocity_scale_factor_q}));
	assign actual_div = signed'(drive_actual_velocity_in) /
	                    32'(signed'({9'h000, velocity_scale_factor_q}));

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			target_velocity_out <= 32'h0000_0000;
			actual_velocity_out <= 16'h0000;
		end
		else
		begin
			target_velocity_out <= target_d;
			if (actual_div > 32'sd32767)
				actual_velocity_out <= 16'h7FFF;
			else if (actual_div < -32'sd32768)
				actual_velocity_out <= 16'h8000;
			else
				actual_velocity_out <= actual_div[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link events
	assign req_ok = state_req_in && connected_q &&
	                (state_req_code_in == `RUN_CODE_INIT ||
	                 state_req_code_in == `RUN_CODE_PREOP ||
	                 state_req_code_in == `RUN_CODE_SAFEOP ||
	                 state_req_code_in == `RUN_CODE_OP);
	assign wd_expire = (run_q == RUN_OP) &&
	                   (sync_manager_watchdog_time_in != 16'h0000) &&
	                   (wd_ms_q >= sync_manager_watchdog_time_in);
	assign loss      = (connected_q && conn_lost_in) || wd_expire;
	assign tout_done = failing_q && (comm_timeout_q == 16'h0000 ||
	                   tout_s_q >= comm_timeout_q);

	// Watchdog restarts on every good process data frame
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			wd_ms_q <= 16'h0000;
		else if (run_q != RUN_OP || frame_ok_in)
			wd_ms_q <= 16'h0000;
		else if (ms_tick && wd_ms_q != 16'hFFFF)
			wd_ms_q <= wd_ms_q + 16'h0001;
	end

	// Connection tracking
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			connected_q <= 1'b0;
			ever_open_q <= 1'b0;
		end
		else if (conn_open_in)
		begin
			connected_q <= 1'b1;
			ever_open_q <= 1'b1;
		end
		else if (conn_lost_in)
			connected_q <= 1'b0;
	end

	// Run state machine; watchdog expiry outranks a command in the same cycle
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			run_q <= RUN_INIT;
		else if (conn_lost_in)
			run_q <= RUN_INIT;
		else if (wd_expire)
			run_q <= RUN_SAFEOP;
		else if (req_ok)
		begin
			case (state_req_code_in)
				`RUN_CODE_PREOP:  run_q <= RUN_PREOP;
				`RUN_CODE_SAFEOP: run_q <= RUN_SAFEOP;
				`RUN_CODE_OP:     run_q <= RUN_OP;
				default:          run_q <= RUN_INIT;
			endcase
		end
	end

	always_comb
	begin
		case (run_q)
			RUN_PREOP:  link_run_state_out = `RUN_CODE_PREOP;
			RUN_SAFEOP: link_run_state_out = `RUN_CODE_SAFEOP;
			RUN_OP:     link_run_state_out = `RUN_CODE_OP;
			default:    link_run_state_out = `RUN_CODE_INIT;
		endcase
	end

	// Timeout runs in whole seconds of the millisecond timebase
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			failing_q <= 1'b0;
			tout_ms_q <= 10'h000;
			tout_s_q  <= 16'h0000;
		end
		else if (loss)
		begin
			failing_q <= 1'b1;
			tout_ms_q <= 10'h000;
			tout_s_q  <= 16'h0000;
		end
		else if (tout_done || conn_open_in || req_ok)
			failing_q <= 1'b0;
		else if (failing_q && ms_tick)
		begin
			if (tout_ms_q == `SEC_MS)
			begin
				tout_ms_q <= 10'h000;
				tout_s_q  <= tout_s_q + 16'h0001;
			end
			else
				tout_ms_q <= tout_ms_q + 10'h001;
		end
	end

	// Generic status: timeout over loss over command over open
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			link_status_q <= `GEN_INITIALIZING;
		else if (tout_done)
			link_status_q <= `GEN_FAULTED;
		else if (loss)
			link_status_q <= `GEN_FAILING;
		else if (req_ok && state_req_code_in == `RUN_CODE_OP)
			link_status_q <= `GEN_OPERATIONAL;
		else if (req_ok && (state_req_code_in == `RUN_CODE_PREOP ||
		                    state_req_code_in == `RUN_CODE_SAFEOP))
			link_status_q <= `GEN_PREOP;
		else if (conn_open_in)
			link_status_q <= `GEN_STOPPED;
	end

	// Fault is sticky; a raise in the clearing cycle survives the clear
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			fault_q <= 1'b0;
		else if (tout_done)
			fault_q <= 1'b1;
		else if (fault_clr)
			fault_q <= 1'b0;
	end

	assign generic_link_status_out    = link_status_q;
	assign fieldbus_timeout_fault_out = fault_q;
	assign operate_mode_out           = oper_mode_q;

	////////////////////////////////////////////////////////////////////////
	// Frame rate diagnostics
	frame_rate_counter u_rate
	(
		.clock_in        (clock_in),
		.rst_b_in        (rst_b_in),
		.ms_tick_in      (ms_tick),
		.frame_ok_in     (frame_ok_in),
		.frame_err_in    (frame_err_in),
		.comm_status_out (comm_status)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path; data stand only in the cycle after the strobe
	always_comb
	begin
		read_mux = 32'h0000_0000;
		if (reg_addr_in == `OFS_PANEL_ALIAS)
			read_mux = {16'h0000, panel_alias_q};
		else if (reg_addr_in == `OFS_NODE_ID)
			read_mux = {16'h0000, node_id_q};
		else if (reg_addr_in == `OFS_VEL_FACTOR)
			read_mux = {25'h0000000, velocity_scale_factor_q};
		else if (reg_addr_in == `OFS_COMM_TIMEOUT)
			read_mux = {16'h0000, comm_timeout_q};
		else if (reg_addr_in == `OFS_OPER_MODE)
			read_mux = {30'h00000000, oper_mode_q};
		else if (reg_addr_in == `OFS_DESC_MODE)
			read_mux = {30'h00000000, description_file_select_mode_q};
		else if (reg_addr_in == `OFS_STATUS)
			read_mux = {22'h000000, ethernet_tunnelling_in, fault_q, 1'b0,
			            link_run_state_out, 1'b0, link_status_q};
		else if (reg_addr_in == `OFS_COMM_STATUS)
			read_mux = {16'h0000, comm_status};
		else if (reg_addr_in == `OFS_WDOG_TIME)
			read_mux = {16'h0000, sync_manager_watchdog_time_in};
		else if (reg_addr_in == `OFS_AL_STATUS)
			read_mux = {16'h0000, application_layer_status_in};
		else if (reg_addr_in == `OFS_ACTIVE_ALIAS)
			read_mux = {16'h0000, node_alias_out};
		else if (reg_addr_in == `OFS_PRODUCT)
			read_mux = product_code_in;
		else if (reg_addr_in == `OFS_REVISION)
			read_mux = {16'h0000, revision_in};
		else if (reg_addr_in == `OFS_IP_ADDR)
			read_mux = ip_addr_in;
		else if (reg_addr_in == `OFS_SUBNET)
			read_mux = subnet_in;
		else if (reg_addr_in == `OFS_GATEWAY)
			read_mux = gateway_in;
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			reg_rdata_out <= 32'h0000_0000;
		else if (reg_rd_in)
			reg_rdata_out <= read_mux;
		else
			reg_rdata_out <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	alias_panel_a: assert property (
		panel_alias_q != 16'h0000 |=> node_alias_out == $past(panel_alias_q))
		else $error("panel alias not applied");
	alias_stored_a: assert property (
		alias_taken_q && panel_alias_q == 16'h0000 |=>
		node_alias_out == stored_alias_q && $stable(stored_alias_q))
		else $error("stored alias changed after capture");
	init_hold_a: assert property (
		!ever_open_q |-> link_status_q == `GEN_INITIALIZING)
		else $error("status left initializing before open");
	op_status_a: assert property (
		req_ok && state_req_code_in == `RUN_CODE_OP && !loss |=>
		link_status_q == `GEN_OPERATIONAL && link_run_state_out == `RUN_CODE_OP)
		else $error("operational command not reflected");
	preop_status_a: assert property (
		req_ok && state_req_code_in == `RUN_CODE_SAFEOP && !loss |=>
		link_status_q == `GEN_PREOP && link_run_state_out == `RUN_CODE_SAFEOP)
		else $error("safe-op command not reflected");
	boot_ignore_a: assert property (
		state_req_in && state_req_code_in == `REQ_BOOTSTRAP &&
		!wd_expire && !conn_lost_in |=> $stable(run_q))
		else $error("bootstrap request changed state");
	wd_drop_a: assert property (
		wd_expire && !conn_lost_in |=> run_q == RUN_SAFEOP ##0
		link_status_q == `GEN_FAILING)
		else $error("watchdog expiry did not drop state");
	fault_zero_a: assert property (
		loss && comm_timeout_q == 16'h0000 |=> ##1 fault_q &&
		link_status_q == `GEN_FAULTED)
		else $error("fault not raised after zero timeout");
	failing_hold_a: assert property (
		loss && comm_timeout_q != 16'h0000 && !fault_q && !tout_done |=>
		(link_status_q == `GEN_FAILING && !fault_q) [*2])
		else $error("failing not shown during timeout");
	unity_factor_a: assert property (
		velocity_scale_factor_q == `RST_VEL_FACTOR |=>
		target_velocity_out == 32'(signed'($past(rx_target_velocity_in))))
		else $error("unity factor altered target");
	read_idle_a: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
		else $error("read data outside read cycle");

	op_reached_c: cover property (req_ok ##[1:20] run_q == RUN_OP);
	wd_expire_c:  cover property (wd_expire);
	fault_c:      cover property (loss ##[1:50] fault_q);
	boot_req_c:   cover property (state_req_in &&
	                              state_req_code_in == `REQ_BOOTSTRAP);

endmodule

// ===== tb/fieldbus_master_model.sv
// Far-side master model: link events, frame pulses and configured values.
// Assumes the device samples every pulse on the rising clock edge.
module fieldbus_master_model
(
	input  wire logic        clock_in,
	output logic      [4:0]  ev_out,
	output logic      [2:0]  code_out,
	output logic      [15:0] wdog_ms_out,
	output logic             tunnel_out
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////
	// Set-up values stay put, as a configured master leaves them
	initial
	begin
		ev_out = 5'h00;
		code_out = 3'h0;
		wdog_ms_out = 16'h0002;
		tunnel_out = 1'b1;
	end

	// One-cycle pulse: 0 open, 1 lost, 2 request, 3 good, 4 bad frame
	task automatic pulse(input int sel, input logic [2:0] code);
	begin
		@(posedge clock_in);
		ev_out <= 5'h01 << sel;
		code_out <= code;
		@(posedge clock_in);
		ev_out <= 5'h00;
	end
	endtask
endmodule

// ===== tb/tb_fieldbus_node_status_monitor.sv
// Bench for the node status monitor: registers, alias, velocity path,
// link states, watchdog fault and frame counting.
// Assumes fieldbus_master_model as the far side.
`include "fieldbus_monitor_regs.svh"
module tb_fieldbus_node_status_monitor;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [15:0] rx_v = 16'h0;
	logic [31:0] act_v = 32'h0;
	logic [31:0] info = 32'hA5C3_0F96;
	logic [15:0] nv_alias = 16'h1234;
	logic [31:0] rdata, tgt;
	logic [4:0]  ev;
	logic [2:0]  code, gls, run;
	logic [15:0] wdog, actq, alias_o, nid;
	logic [1:0]  opm;
	logic        tun, flt;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	////////////////////////////////////////////////////////////////////
	// Millisecond shortened to 4 cycles to keep the run short
	fieldbus_node_status_monitor #(.MS_CYCLES(4)) i_fieldbus_node_status_monitor
	(
		.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .conn_open_in(ev[0]), .conn_lost_in(ev[1]),
		.state_req_in(ev[2]), .state_req_code_in(code),
		.frame_ok_in(ev[3]), .frame_err_in(ev[4]),
		.stored_alias_in(nv_alias), .sync_manager_watchdog_time_in(wdog),
		.application_layer_status_in(info[15:0]), .product_code_in(info),
		.revision_in(info[31:16]), .ethernet_tunnelling_in(tun),
		.ip_addr_in(info), .subnet_in(~info), .gateway_in(info),
		.rx_target_velocity_in(rx_v), .drive_actual_velocity_in(act_v),
		.target_velocity_out(tgt), .actual_velocity_out(actq),
		.node_alias_out(alias_o), .node_identification_value_out(nid),
		.generic_link_status_out(gls), .link_run_state_out(run),
		.operate_mode_out(opm), .fieldbus_timeout_fault_out(flt)
	);
	fieldbus_master_model i_fieldbus_master_model
	(
		.clock_in(clock_in), .ev_out(ev), .code_out(code),
		.wdog_ms_out(wdog), .tunnel_out(tun)
	);

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #25 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
	begin
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	task automatic chk(input string what, input logic [31:0] exp, got);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	end
	endtask

	// Bus cycles: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clock_in);
		{addr, wdata, wr_s} <= {a, d, 1'b1};
		@(posedge clock_in);
		wr_s <= 1'b0;
	end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
	begin
		@(posedge clock_in);
		{addr, rd_s} <= {a, 1'b1};
		@(posedge clock_in);
		rd_s <= 1'b0;
		#1 chk("register", e, rdata);
	end
	endtask
	task automatic step(input int n);
	begin
		repeat (n) @(posedge clock_in);
		#1;
	end
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic vel(input logic [31:0] f, et, a, input logic [15:0] r, ea);
	begin
		wr(`OFS_VEL_FACTOR, f);
		{rx_v, act_v} <= {r, a};
		step(2);
		chk("target", et, tgt);
		chk("actual", {16'h0, ea}, {16'h0, actq});
	end
	endtask

	task automatic link();
	int n;
	begin
		i_fieldbus_master_model.pulse(2, 3'h5);
		#1 chk("early", 32'h1, {29'h0, gls});
		i_fieldbus_master_model.pulse(0, 3'h0);
		i_fieldbus_master_model.pulse(2, 3'h3);
		#1 chk("preop", 32'h63, {gls, 1'b0, run});
		i_fieldbus_master_model.pulse(2, 3'h6);
		#1 chk("boot", 32'h63, {gls, 1'b0, run});
		i_fieldbus_master_model.pulse(2, 3'h4);
		#1 chk("safeop", 32'h64, {gls, 1'b0, run});
		i_fieldbus_master_model.pulse(2, 3'h5);
		#1 chk("op", 32'h35, {gls, 1'b0, run});
		for (n = 0; n < 60 && run === 3'h5; n++)
			step(1);
		chk("expiry", 32'h54, {gls, 1'b0, run});
		for (n = 0; n < 60 && flt !== 1'b1; n++)
			step(1);
		chk("fault", 32'h9, {gls, flt});
		wr(`OFS_CONTROL, 32'h1);
		#1 chk("clear", 32'h0, {31'h0, flt});
		// One second of timeout: Failing stands for 1000 ticks of 4 cycles
		wr(`OFS_COMM_TIMEOUT, 32'h1);
		i_fieldbus_master_model.pulse(1, 3'h0);
		#1 chk("lost", 32'h1, {29'h0, run});
		chk("failing", 32'hA, {gls, flt});
		for (n = 0; n < 4100 && flt !== 1'b1; n++)
			step(1);
		chk("delay", 32'h1, {31'h0, n > 3997 && n < 4002});
		chk("faulted", 32'h9, {gls, flt});
	end
	endtask

	initial
	begin
		repeat (12) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (3) i_fieldbus_master_model.pulse(3, 3'h0);
		repeat (2) i_fieldbus_master_model.pulse(4, 3'h0);
		nv_alias <= 16'h4321;
		rchk(`OFS_COMM_STATUS, 32'h0);
		chk("alias", 32'h1234, {16'h0, alias_o});
		rchk(`OFS_STATUS, 32'h211);
		rchk(`OFS_NODE_ID, 32'h1);
		wr(`OFS_PANEL_ALIAS, 32'h55);
		step(2);
		chk("alias", 32'h55, {16'h0, alias_o});
		wr(`OFS_NODE_ID, 32'h7);
		wr(`OFS_NODE_ID, 32'h0);
		step(2);
		chk("node id", 32'h7, {16'h0, nid});
		for (int m = 1; m < 4; m++)
		begin
			wr(`OFS_OPER_MODE, m);
			wr(`OFS_DESC_MODE, m);
			step(2);
			chk("mode", m, {30'h0, opm});
			rchk(`OFS_DESC_MODE, m);
		end
		vel(32'h1, 32'hFFFF_8000, 32'h7FFF, 16'h8000, 16'h7FFF);
		vel(32'hA, 32'h3E8, 32'h3E8, 16'h0064, 16'h0064);
		vel(32'h64, 32'hFFFF_FF9C, 32'hFFFF_FE0C, 16'hFFFF, 16'hFFFB);
		rchk(`OFS_WDOG_TIME, 32'h2);
		rchk(`OFS_AL_STATUS, {16'h0, info[15:0]});
		rchk(`OFS_PRODUCT, info);
		rchk(`OFS_REVISION, {16'h0, info[31:16]});
		rchk(`OFS_SUBNET, ~info);
		rchk(8'h50, 32'h0);
		step(4100 - cycles);
		rchk(`OFS_COMM_STATUS, 32'h20);
		link();
		// Power cycle: the alias stored meanwhile takes over only now
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		step(3);
		chk("alias", 32'h4321, {16'h0, alias_o});
		chk("restart", 32'h1, {29'h0, gls});
		tally_and_finish();
	end
endmodule
